// >>> common/orsq_map.vh
// Constants for the origin-return sequencer: command codes, bit positions,
// register selection codes and widths. Definitions only.
`ifndef ORSQ_MAP_VH
`define ORSQ_MAP_VH
// Port addresses
`define ORSQ_A_CMD 2'h0
`define ORSQ_A_DATA 2'h1
`define ORSQ_A_POS 2'h2
`define ORSQ_A_FEED 2'h3
`define ORSQ_A_STAT 2'h1
// Command classes (upper two bits)
`define ORSQ_CLS_START 2'h0
`define ORSQ_CLS_CTRL 2'h1
`define ORSQ_CLS_OUT 2'h3
`define ORSQ_CLS_SEL 2'h2
// Start mode codes
`define ORSQ_START_FH 8'h11
`define ORSQ_START_ACC 8'h15
`define ORSQ_START_FL 8'h10
`define ORSQ_START_DEC 8'h1D
`define ORSQ_STOP_NOW 8'h08
`define ORSQ_START_INT_BIT 5
// Control mode bits
`define ORSQ_CC_DIR 3
`define ORSQ_CC_MAXF 2
`define ORSQ_CC_SDEN 1
`define ORSQ_CC_ORG 0
// Output mode bits
`define ORSQ_OC_PMASK 2
`define ORSQ_OC_OMASK 1
// Register selection codes
`define ORSQ_SEL_FEED 8'h80
`define ORSQ_SEL_FL 8'h81
`define ORSQ_SEL_FH 8'h82
`define ORSQ_SEL_RAMP 8'h83
`define ORSQ_SEL_SCALE 8'h84
`define ORSQ_SEL_ENV 8'h87
// Environment register bits
`define ORSQ_ENV_ORDS 3
`define ORSQ_ENV_ORRS 4
`define ORSQ_ENV_PSTP 8
// Widths and reset values
`define ORSQ_W 24
`define ORSQ_ZERO24 24'h000000
`define ORSQ_ONE24 24'h000001
`define ORSQ_LSB_MASK 24'h0000FF
// Rate clock: cycles of core_clk per speed unit
`define ORSQ_TICK_DIV 16'h0064
`define ORSQ_ONE16 16'h0001
`endif

// >>> src/orsq_sync.v
// Three-stage synchroniser with agreement filter for one active-low pin.
// Assumes core_clk domain; pin is asynchronous.
`timescale 1ns/10ps
module orsq_sync (
   input wire core_clk,
   input wire rst,
   input wire clk_en,
   input wire pin_n,
   output reg level_n_q,
   output reg fall_q
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   // Chain; change accepted once stages two and three agree
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
         level_n_q <= 1'b1;
         fall_q <= 1'b0;
      end else if (clk_en) begin
         s1_q <= pin_n;
         s2_q <= s1_q;
         s3_q <= s2_q;
         fall_q <= 1'b0;
         if (s2_q == s3_q) begin
            level_n_q <= s3_q;
            fall_q <= level_n_q & ~s3_q; // R22
         end
      end
   end
endmodule

// >>> src/orsq_rate.v
// Step rate generator: phase accumulator stepping at a speed word.
// Assumes core_clk domain and a tick strobe from the caller.
`timescale 1ns/10ps
module orsq_rate (
   input wire core_clk,
   input wire rst,
   input wire clk_en,
   input wire run,
   input wire tick,
   input wire [23:0] speed,
   output reg step_q
);
   reg [24:0] acc_q;
   wire [24:0] sum;
   assign sum = {1'b0, acc_q[23:0]} + {1'b0, speed};
   // Overflow of the accumulator is one step
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         acc_q <= 25'h0;
         step_q <= 1'b0;
      end else if (clk_en) begin
         step_q <= 1'b0;
         if (!run) begin
            acc_q <= 25'h0;
         end else if (tick) begin
            acc_q <= {1'b0, sum[23:0]};
            step_q <= sum[24];
         end
      end
   end
endmodule

// >>> src/orsq_top.v
// Origin-return sequencer: command decode, register loading and step control.
// Assumes one 200 MHz core clock and a host on a plain strobe port.
//
// Function
// [R1] Pulse until origin input goes low
// [R2] Direction bit: 0 plus, 1 minus
// [R3] No start while origin already low
// [R4] Refused start still raises stop interrupt
// [R5] Feed-limit variant stops at zero count
// [R6] Feed counter decrements per pulse, readable
// [R7] Slowdown input decelerates to low speed
// [R8] Slowdown enable ignores or honours both inputs
// [R9] Origin stop immediate or decelerated
// [R10] Auto clear position on origin edge
// [R11] Clear plus decel: stop at low speed
// [R12] Position keeps counting overrun pulses
// [R13] Pulse mask suppresses output pulses
// [R14] Count hold freezes position counter
// [R15] Decode control codes 41h and 43h
// [R16] Decode start codes 11h and 15h
// [R17] Host loads select code then three bytes
// [R18] Accept 83h ramp and 81h low speed
// [R19] Constant start stops without ramp
// [R20] Mode decoded from mask and mode bits
// [R21] Start code 08h stops at once
// [R22] Sensor inputs synchronised, edges detected
// [R23] Register updates only on lower byte
`timescale 1ns/10ps
`include "orsq_map.vh"
module orsq_top (
   input wire core_clk,
   input wire rst,
   input wire clk_en,
   input wire [1:0] addr,
   input wire [7:0] wdata,
   input wire wr_stb,
   input wire rd_stb,
   output reg [23:0] rdata_q,
   input wire origin_n,
   input wire slow_plus_n,
   input wire slow_minus_n,
   output reg step_plus_q,
   output reg step_minus_q,
   output reg busy_q,
   output reg int_q
);
   // ----------------------------------------------------------------
   // State machine codes
   // ----------------------------------------------------------------
   localparam ST_IDLE = 3'b001;
   localparam ST_RUN = 3'b010;
   localparam ST_DEC = 3'b100;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   reg [2:0] st_q;
   reg [3:0] ctrl_q;
   reg [2:0] outm_q;
   reg [7:0] sel_q;
   reg [1:0] bcnt_q;
   reg [15:0] stage_q;
   reg [23:0] env_q;
   reg [23:0] fl_q;
   reg [23:0] fh_q;
   reg [23:0] ramp_q;
   reg [23:0] scale_q;
   reg [23:0] feed_q;
   reg [23:0] pos_q;
   reg [23:0] speed_q;
   reg [15:0] tdiv_q;
   reg [15:0] rdiv_q;
   reg accel_q;
   reg int_req_q;
   reg dir_q;
   reg maxf_q;

   wire org_n;
   wire org_fall;
   wire sp_n;
   wire sm_n;
   wire step;
   wire tick;
   wire ramp_tick;
   wire slow_on;
   wire mode_org;
   wire cmd_wr;
   wire data_wr;
   wire [23:0] full_word;
   wire [23:0] fh_eff;
   wire [23:0] fl_eff;
   wire [7:0] start_code;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   orsq_sync u_sync_org (
      .core_clk(core_clk),
      .rst(rst),
      .clk_en(clk_en),
      .pin_n(origin_n),
      .level_n_q(org_n),
      .fall_q(org_fall)
   );
   orsq_sync u_sync_sp (
      .core_clk(core_clk),
      .rst(rst),
      .clk_en(clk_en),
      .pin_n(slow_plus_n),
      .level_n_q(sp_n),
      .fall_q()
   );
   orsq_sync u_sync_sm (
      .core_clk(core_clk),
      .rst(rst),
      .clk_en(clk_en),
      .pin_n(slow_minus_n),
      .level_n_q(sm_n),
      .fall_q()
   );

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   assign cmd_wr = wr_stb & (addr == `ORSQ_A_CMD);
   assign data_wr = wr_stb & (addr == `ORSQ_A_DATA);
   assign full_word = {stage_q, wdata};
   // Start code with the interrupt request bit masked off
   assign start_code = {3'b000, wdata[4:0]};
   // Origin mode needs mode bit set and output mask clear
   assign mode_org = ctrl_q[`ORSQ_CC_ORG] & ~outm_q[`ORSQ_OC_OMASK]; // R20
   // Either slowdown input counts when enabled
   assign slow_on = ctrl_q[`ORSQ_CC_SDEN] & (~sp_n | ~sm_n); // R8
   assign fh_eff = (fh_q == `ORSQ_ZERO24) ? `ORSQ_ONE24 : fh_q;
   assign fl_eff = (fl_q == `ORSQ_ZERO24) ? `ORSQ_ONE24 : fl_q;
   assign tick = (tdiv_q == `ORSQ_ONE16);
   assign ramp_tick = (rdiv_q == `ORSQ_ONE16);

   // ----------------------------------------------------------------
   // Step rate generator
   // ----------------------------------------------------------------
   orsq_rate u_rate (
      .core_clk(core_clk),
      .rst(rst),
      .clk_en(clk_en),
      .run(~st_q[0]),
      .tick(tick),
      .speed(speed_q),
      .step_q(step)
   );

   // Speed-unit and ramp-unit prescalers
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tdiv_q <= `ORSQ_TICK_DIV;
         rdiv_q <= `ORSQ_ONE16;
      end else if (clk_en) begin
         // Reload only on a tick so a zero scale still runs at the default rate
         if (tick)
            tdiv_q <= (scale_q[15:0] == 16'h0000) ? `ORSQ_TICK_DIV : scale_q[15:0];
         else
            tdiv_q <= tdiv_q - `ORSQ_ONE16;
         if (ramp_tick || ramp_q[15:0] == 16'h0000)
            rdiv_q <= (ramp_q[15:0] == 16'h0000) ? `ORSQ_ONE16 : ramp_q[15:0];
         else
            rdiv_q <= rdiv_q - `ORSQ_ONE16;
      end
   end

   // ----------------------------------------------------------------
   // Command and register write buffer
   // ----------------------------------------------------------------
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= 4'h0;
         outm_q <= 3'h0;
         sel_q <= 8'h00;
         bcnt_q <= 2'h0;
         stage_q <= 16'h0000;
         env_q <= `ORSQ_ZERO24;
         fl_q <= `ORSQ_ZERO24;
         fh_q <= `ORSQ_ZERO24;
         ramp_q <= `ORSQ_ZERO24;
         scale_q <= `ORSQ_ZERO24;
      end else if (clk_en) begin
         if (cmd_wr) begin
            case (wdata[7:6])
               `ORSQ_CLS_CTRL: ctrl_q <= wdata[3:0]; // R15
               `ORSQ_CLS_OUT: outm_q <= wdata[2:0];
               `ORSQ_CLS_SEL: begin
                  sel_q <= wdata; // R17
                  bcnt_q <= 2'h0;
                  stage_q <= 16'h0000;
               end
               default: ;
            endcase
         end else if (data_wr) begin
            if (bcnt_q == 2'h0) begin
               stage_q[15:8] <= wdata;
               bcnt_q <= 2'h1;
            end else if (bcnt_q == 2'h1) begin
               stage_q[7:0] <= wdata;
               bcnt_q <= 2'h2;
            end else begin
               // Lower byte commits the whole word
               bcnt_q <= 2'h0; // R23
               case (sel_q)
                  `ORSQ_SEL_FL: fl_q <= full_word; // R18
                  `ORSQ_SEL_FH: fh_q <= full_word;
                  `ORSQ_SEL_RAMP: ramp_q <= full_word; // R18
                  `ORSQ_SEL_SCALE: scale_q <= full_word;
                  `ORSQ_SEL_ENV: env_q <= full_word;
                  default: ;
               endcase
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Operation sequencer
   // ----------------------------------------------------------------
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_q <= ST_IDLE;
         speed_q <= `ORSQ_ZERO24;
         accel_q <= 1'b0;
         int_req_q <= 1'b0;
         dir_q <= 1'b0;
         maxf_q <= 1'b0;
         int_q <= 1'b0;
         busy_q <= 1'b0;
      end else if (clk_en) begin
         if (rd_stb && addr == `ORSQ_A_STAT)
            int_q <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               if (cmd_wr && wdata[7:6] == `ORSQ_CLS_START &&
                   (start_code == `ORSQ_START_FH ||
                    start_code == `ORSQ_START_ACC ||
                    start_code == `ORSQ_START_FL)) begin
                  if (mode_org && !org_n) begin
                     // Refused start still signals the stop
                     if (wdata[`ORSQ_START_INT_BIT])
                        int_q <= 1'b1; // R3 R4
                  end else if (mode_org) begin
                     st_q <= ST_RUN; // R16
                     busy_q <= 1'b1;
                     dir_q <= ctrl_q[`ORSQ_CC_DIR]; // R2
                     maxf_q <= ctrl_q[`ORSQ_CC_MAXF];
                     int_req_q <= wdata[`ORSQ_START_INT_BIT];
                     accel_q <= (start_code == `ORSQ_START_ACC);
                     if (start_code == `ORSQ_START_FL)
                        speed_q <= fl_eff;
                     else if (start_code == `ORSQ_START_ACC)
                        speed_q <= fl_eff;
                     else
                        speed_q <= fh_eff; // R16
                  end
               end
            end
            ST_RUN: begin
               if (accel_q && ramp_tick && speed_q < fh_eff)
                  speed_q <= speed_q + `ORSQ_ONE24;
               if ((cmd_wr && wdata == `ORSQ_STOP_NOW) || // R21
                   (!org_n && !(env_q[`ORSQ_ENV_ORDS] && accel_q)) || // R1 R19
                   (maxf_q && feed_q == `ORSQ_ZERO24)) begin // R5
                  st_q <= ST_IDLE;
                  busy_q <= 1'b0;
                  if (int_req_q)
                     int_q <= 1'b1;
               end else if ((cmd_wr && wdata == `ORSQ_START_DEC) ||
                            (!org_n && env_q[`ORSQ_ENV_ORDS]) || // R9 R11
                            (slow_on && accel_q)) begin // R7
                  st_q <= ST_DEC;
               end
            end
            ST_DEC: begin
               if (ramp_tick && speed_q > fl_eff)
                  speed_q <= speed_q - `ORSQ_ONE24;
               if ((cmd_wr && wdata == `ORSQ_STOP_NOW) ||
                   (maxf_q && feed_q == `ORSQ_ZERO24) ||
                   (!org_n && !env_q[`ORSQ_ENV_ORDS]) || // R9
                   (speed_q <= fl_eff &&
                    (!org_n || !env_q[`ORSQ_ENV_ORDS] && slow_on == 1'b0))) begin // R7 R11
                  st_q <= ST_IDLE;
                  busy_q <= 1'b0;
                  if (int_req_q)
                     int_q <= 1'b1;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Step outputs and counters
   // ----------------------------------------------------------------
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         step_plus_q <= 1'b0;
         step_minus_q <= 1'b0;
         feed_q <= `ORSQ_ZERO24;
         pos_q <= `ORSQ_ZERO24;
      end else if (clk_en) begin
         // Masked pulses run internally only
         step_plus_q <= step & ~st_q[0] & ~dir_q & ~outm_q[`ORSQ_OC_PMASK]; // R13
         step_minus_q <= step & ~st_q[0] & dir_q & ~outm_q[`ORSQ_OC_PMASK]; // R13
         if (data_wr && bcnt_q == 2'h2 && sel_q == `ORSQ_SEL_FEED)
            feed_q <= full_word;
         else if (step && !st_q[0] && feed_q != `ORSQ_ZERO24)
            feed_q <= feed_q - `ORSQ_ONE24; // R6
         if (org_fall && env_q[`ORSQ_ENV_ORRS] && !st_q[0])
            pos_q <= `ORSQ_ZERO24; // R10 R11
         else if (step && !st_q[0] && !env_q[`ORSQ_ENV_PSTP]) begin // R14
            if (dir_q)
               pos_q <= pos_q - `ORSQ_ONE24; // R12
            else
               pos_q <= pos_q + `ORSQ_ONE24; // R12
         end
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata_q <= `ORSQ_ZERO24;
      end else if (clk_en) begin
         rdata_q <= `ORSQ_ZERO24;
         if (rd_stb) begin
            case (addr)
               `ORSQ_A_POS: rdata_q <= pos_q;
               `ORSQ_A_FEED: rdata_q <= feed_q; // R6
               `ORSQ_A_STAT: rdata_q <= {18'h0, ~org_n, int_q, st_q, busy_q};
               default: rdata_q <= {17'h0, outm_q, ctrl_q};
            endcase
         end
      end
   end
endmodule

// >>> sim/orsq_assertions.sv
// Port checker for the origin-return sequencer.
// Assumes clk_en high and mode commands written while idle.
`timescale 1ns/10ps
module orsq_chk (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [23:0] rdata_q,
   input wire logic origin_n,
   input wire logic slow_plus_n,
   input wire logic slow_minus_n,
   input wire logic step_plus_q,
   input wire logic step_minus_q,
   input wire logic busy_q,
   input wire logic int_q
);
   logic org_q, dir_q, pmask_q, fh_q;
   logic [3:0] low_q;
   wire cmd_wr = wr_stb && addr == 2'h0;
   wire fh_wr = cmd_wr && wdata[7:6] == 2'h0 && wdata[4:0] == 5'h11;
   // ------
   // Shadow of host mode bits and origin low time
   // ------
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         {org_q, dir_q, pmask_q, fh_q} <= 4'h0;
         low_q <= 4'h0;
      end else begin
         if (cmd_wr && wdata[7:4] == 4'h4)
            {dir_q, org_q} <= {wdata[3], wdata[0]};
         if (cmd_wr && wdata[7:6] == 2'h3)
            pmask_q <= wdata[2];
         if (fh_wr)
            fh_q <= 1'b1;
         else if (cmd_wr && wdata[4:0] == 5'h15)
            fh_q <= 1'b0;
         low_q <= origin_n ? 4'h0 : (low_q == 4'hF ? low_q : low_q + 4'h1);
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence start_held_s; fh_wr && org_q && low_q >= 4'h8; endsequence
   sequence org_hit_s; busy_q && org_q && fh_q && $fell(origin_n); endsequence
   step_excl_a: assert property (!(step_plus_q && step_minus_q))
      else $error("both step outputs high");
   step_dir_a: assert property ((step_plus_q |-> !dir_q) and (step_minus_q |-> dir_q))
      else $error("step on wrong direction");
   step_busy_a: assert property (step_plus_q || step_minus_q |-> busy_q || $past(busy_q))
      else $error("step while idle");
   org_stop_a: assert property (org_hit_s |-> ##[1:8] !busy_q)
      else $error("no stop at origin");
   refuse_run_a: assert property (start_held_s |-> ##1 !busy_q [*4])
      else $error("start taken at origin");
   refuse_int_a: assert property (start_held_s ##0 wdata[5] |-> ##[1:3] int_q)
      else $error("no interrupt on refused start");
   stop_now_a: assert property (cmd_wr && wdata == 8'h08 |-> ##[1:3] !busy_q)
      else $error("stop command ignored");
   pulse_mask_a: assert property (pmask_q |-> !step_plus_q && !step_minus_q)
      else $error("step while masked");
   rdata_idle_a: assert property (!$past(rd_stb) |-> rdata_q == 24'h000000)
      else $error("read data outside read cycle");
   int_clear_a: assert property (rd_stb && addr == 2'h1 && !busy_q |=> !int_q)
      else $error("interrupt not cleared by read");
endmodule
bind orsq_top orsq_chk u_chk (
   .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .addr(addr), .wdata(wdata),
   .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q), .origin_n(origin_n),
   .slow_plus_n(slow_plus_n), .slow_minus_n(slow_minus_n), .step_plus_q(step_plus_q),
   .step_minus_q(step_minus_q), .busy_q(busy_q), .int_q(int_q)
);

// >>> sim/orsq_motor.sv
// Motor driver model with origin and slowdown sensors on pull-ups.
// Assumes one step pulse moves the carriage one unit.
`timescale 1ns/10ps
module orsq_motor (
   input wire logic core_clk,
   input wire logic step_plus_q,
   input wire logic step_minus_q,
   input int org_hi,
   input int org_lo,
   input int sd_hi,
   input int sd_lo,
   output logic origin_n,
   output logic slow_plus_n,
   output logic slow_minus_n
);
   int pos = 0;
   int n_plus = 0;
   int n_minus = 0;
   // Carriage position and step counts
   always @(posedge core_clk) begin
      if (step_plus_q) begin
         pos <= pos + 1;
         n_plus <= n_plus + 1;
      end
      if (step_minus_q) begin
         pos <= pos - 1;
         n_minus <= n_minus + 1;
      end
   end
   // Sensors pull low inside their zones
   always @* begin
      origin_n = !(pos >= org_hi || pos <= org_lo);
      slow_plus_n = !(pos >= sd_hi);
      slow_minus_n = !(pos <= sd_lo);
   end
endmodule

// >>> sim/orsq_top_test.sv
// Self-checking bench for the origin-return sequencer.
// Assumes the checker is bound from its own file.
`timescale 1ns/10ps
`include "orsq_map.vh"
module orsq_top_test;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic [23:0] rd_val;
   wire [23:0] rdata_q;
   wire origin_n, slow_plus_n, slow_minus_n, step_plus_q, step_minus_q, busy_q, int_q;
   int org_hi = 1000;
   int org_lo = -1000;
   int sd_hi = 1000;
   int error_cnt = 0;
   int check_count = 0;
   int cycles = 0;
   int p0;
   orsq_top uut (
      .core_clk(core_clk), .rst(rst), .clk_en(1'b1), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q), .origin_n(origin_n),
      .slow_plus_n(slow_plus_n), .slow_minus_n(slow_minus_n), .step_plus_q(step_plus_q),
      .step_minus_q(step_minus_q), .busy_q(busy_q), .int_q(int_q));
   orsq_motor m (
      .core_clk(core_clk), .step_plus_q(step_plus_q), .step_minus_q(step_minus_q),
      .org_hi(org_hi), .org_lo(org_lo), .sd_hi(sd_hi), .sd_lo(-1000),
      .origin_n(origin_n), .slow_plus_n(slow_plus_n), .slow_minus_n(slow_minus_n));
   // ------
   // Clock, timeout and shared tasks
   // ------
   initial forever #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         error_cnt = error_cnt + 1;
         end_of_test;
      end
   end
   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge core_clk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a);
      @(posedge core_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      #1 rd_val = rdata_q;
   endtask
   task automatic load(input logic [7:0] sel, input logic [23:0] v);
      wr(`ORSQ_A_CMD, sel);
      wr(`ORSQ_A_DATA, v[23:16]);
      wr(`ORSQ_A_DATA, v[15:8]);
      wr(`ORSQ_A_DATA, v[7:0]);
   endtask
   task automatic start(input logic [7:0] code);
      p0 = m.n_plus;
      wr(`ORSQ_A_CMD, code);
      repeat (3) @(posedge core_clk);
      #1 chk("busy run", 24'h000001, {23'h0, busy_q});
   endtask
   task automatic wait_idle;
      for (int n = 0; n < 8000 && busy_q !== 1'b0; n++)
         @(posedge core_clk);
      #1 chk("busy end", 24'h000000, {23'h0, busy_q});
   endtask
   // ------
   // Scenarios
   // ------
   task automatic t_plus_minus;
      load(8'h80, 24'h0003E8);
      org_hi = 20;
      wr(`ORSQ_A_CMD, 8'h41);
      wr(`ORSQ_A_CMD, 8'hE0);
      start(8'h11);
      wait_idle;
      chk("plus steps", 24'h000014, 24'(m.n_plus - p0));
      {org_hi, org_lo} = {32'sd1000, 32'sd0};
      rd(`ORSQ_A_FEED);
      chk("feed", 24'h0003D4, rd_val);
      rd(`ORSQ_A_POS);
      chk("position", 24'h000014, rd_val);
      wr(`ORSQ_A_CMD, 8'h49);
      start(8'h11);
      wait_idle;
      chk("minus steps", 24'h000014, 24'(m.n_minus));
      rd(`ORSQ_A_POS);
      chk("position", 24'h000000, rd_val);
      $display("test plus_minus done");
   endtask
   task automatic t_refuse;
      repeat (10) @(posedge core_clk);
      wr(`ORSQ_A_CMD, 8'h31);
      repeat (4) @(posedge core_clk);
      #1 chk("refused busy", 24'h000000, {23'h0, busy_q});
      chk("refused int", 24'h000001, {23'h0, int_q});
      rd(`ORSQ_A_DATA);
      chk("int cleared", 24'h000000, {23'h0, int_q});
      $display("test refuse done");
   endtask
   task automatic t_feed;
      org_lo = -1000;
      load(8'h80, 24'h000005);
      wr(`ORSQ_A_CMD, 8'h45);
      start(8'h11);
      wait_idle;
      chk("feed steps", 24'h000005, 24'(m.n_plus - p0));
      rd(`ORSQ_A_FEED);
      chk("feed zero", 24'h000000, rd_val);
      $display("test feed done");
   endtask
   task automatic t_mask;
      load(8'h87, 24'h000100);
      org_hi = m.pos + 5;
      wr(`ORSQ_A_CMD, 8'h41);
      wr(`ORSQ_A_CMD, 8'hE4);
      start(8'h11);
      repeat (200) @(posedge core_clk);
      chk("masked steps", 24'h000000, 24'(m.n_plus - p0));
      wr(`ORSQ_A_CMD, 8'h08);
      repeat (3) @(posedge core_clk);
      #1 chk("stop now", 24'h000000, {23'h0, busy_q});
      rd(`ORSQ_A_POS);
      chk("held position", 24'h000005, rd_val);
      wr(`ORSQ_A_CMD, 8'hE0);
      $display("test mask done");
   endtask
   task automatic t_slow;
      load(8'h87, 24'h000018);
      load(8'h81, 24'h100000);
      load(8'h82, 24'h100010);
      load(8'h83, 24'h000001);
      sd_hi = m.pos + 10;
      org_hi = m.pos + 20;
      wr(`ORSQ_A_CMD, 8'h43);
      start(8'h15);
      wait_idle;
      chk("origin reached", 24'h000001, {23'h0, m.pos >= org_hi});
      rd(`ORSQ_A_POS);
      chk("overrun", 24'(m.pos - org_hi), rd_val);
      org_hi = m.pos + 60;
      load(8'h83, 24'h000020);
      wr(`ORSQ_A_CMD, 8'h41);
      start(8'h15);
      wait_idle;
      rd(`ORSQ_A_POS);
      chk("decel overrun", 24'(m.pos - org_hi), rd_val);
      chk("overrun seen", 24'h000001, {23'h0, m.pos > org_hi + 8});
      $display("test slow done");
   endtask
   // Main sequence
   initial begin
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      load(8'h84, 24'h000001);
      load(8'h82, 24'h100000);
      t_plus_minus;
      t_refuse;
      t_feed;
      t_mask;
      t_slow;
      end_of_test;
   end
endmodule
